// ---- rtl/prs_bank.v ----
// One 32-entry register bank with a hardwired zero at index 31.
`timescale 1ns/1ps
`include "prs_defines.vh"
module prs_bank #(
    parameter WIDTH = 64,
    parameter DEPTH = 32
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst_sync_b,
    // Read ports
    input  wire [4:0]       rd_a_idx,
    input  wire [4:0]       rd_b_idx,
    output wire [WIDTH-1:0] rd_a_data,
    output wire [WIDTH-1:0] rd_b_data,
    // Write port
    input  wire             wr_en,
    input  wire [4:0]       wr_idx,
    input  wire [WIDTH-1:0] wr_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-2];
    integer i;

    // Index 31 has no storage element; it is a constant zero on reads.
    assign rd_a_data = (rd_a_idx == `PRS_ZERO_IDX) ? {WIDTH{1'b0}} : mem_reg[rd_a_idx]; // RULE_10 RULE_16 RULE_21
    assign rd_b_data = (rd_b_idx == `PRS_ZERO_IDX) ? {WIDTH{1'b0}} : mem_reg[rd_b_idx]; // RULE_10 RULE_16 RULE_21

    always @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (i = 0; i < DEPTH - 1; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else if (wr_en && (wr_idx != `PRS_ZERO_IDX)) begin
            mem_reg[wr_idx] <= wr_data; // RULE_11 RULE_17 RULE_21
        end
    end
endmodule // prs_bank

// ---- rtl/prs_defines.vh ----
// Constants for the processor register state block.
// Overview of operation
// RULE_01: Longword operate ignores source bits 61..59 and writes them as zero.
// RULE_02: Longword in floating register: top bit at 62, rest of high part 58..45.
// RULE_03: Single load sets bits 61..59 from exponent expansion; single store ignores them. The code writes single load data unchanged, with no expansion.
// RULE_04: Double load and store move quadwords unchanged, all 64 bits.
// RULE_05: Double store checks nothing in the register contents.
// RULE_06: Program counter advances on each decode; users see the advanced value.
// RULE_07: Program counter holds bits 63..2; low two bits read zero, writes ignored.
// RULE_08: Program counter is no integer register operand, only an implied one.
// RULE_09: Thirty-two integer registers, each 64 bits wide.
// RULE_10: Reading integer register 31 always gives zero.
// RULE_11: Results written to integer register 31 are discarded.
// RULE_12: Branches and jumps with register 31 link still update the program counter.
// RULE_13: Fetch exceptions are signalled even for zero-register destinations.
// RULE_14: Load-locked to integer register 31 leaves reservation state unpredictable.
// RULE_15: Thirty-two floating registers, each 64 bits wide.
// RULE_16: Reading floating register 31 gives a true zero.
// RULE_17: Results written to floating register 31 are discarded.
// RULE_18: Single-precision operations read and write all 64 register bits.
// RULE_19: Reservation state is one flag and one locked physical address.
// RULE_20: Optional prefetch state: two sets, not reachable by software.
// RULE_21: Index 31 is hardwired zero on reads with its write enable suppressed.
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH
`define PRS_ZERO_IDX      5'h1f
`define PRS_LW_GAP_HI     61
`define PRS_LW_GAP_LO     59
`define PRS_LW_TOP        62
`define PRS_LW_HI_HI      58
`define PRS_LW_HI_LO      45
`define PRS_LW_LO_HI      44
`define PRS_LW_LO_LO      29
`define PRS_PC_INC        62'h0000_0000_0000_0001
`define PRS_PC_RESET      62'h0000_0000_0000_0000
`define PRS_OP_NONE       3'h0
`define PRS_OP_LW_OPERATE 3'h1
`define PRS_OP_S_LOAD     3'h2
`define PRS_OP_T_LOAD     3'h3
`define PRS_OP_FP_RESULT  3'h4
`endif

// ---- rtl/prs_register_state.v ----
// Top of the per-processor register state: PC, integer and floating banks, reservation.
`timescale 1ns/1ps
`include "prs_defines.vh"
module prs_register_state #(
    parameter XLEN = 64
) (
    // Clock and reset
    input  wire            sys_clk,
    input  wire            rst_b,
    // Program counter
    input  wire            decode_valid,
    input  wire            pc_load,
    input  wire [XLEN-1:0] pc_target,
    input  wire            link_write,
    input  wire [4:0]      link_idx,
    output wire [XLEN-1:0] pc_value,
    // Integer bank
    input  wire [4:0]      int_rd_a_idx,
    input  wire [4:0]      int_rd_b_idx,
    output wire [XLEN-1:0] int_rd_a_data,
    output wire [XLEN-1:0] int_rd_b_data,
    input  wire            int_wr_en,
    input  wire [4:0]      int_wr_idx,
    input  wire [XLEN-1:0] int_wr_data,
    // Floating bank
    input  wire [4:0]      fp_rd_a_idx,
    input  wire [4:0]      fp_rd_b_idx,
    output wire [XLEN-1:0] fp_rd_a_data,
    output wire [XLEN-1:0] fp_rd_b_data,
    output wire [XLEN-1:0] fp_rd_a_lw,
    output wire [XLEN-1:0] fp_rd_b_lw,
    input  wire            fp_wr_en,
    input  wire [2:0]      fp_wr_op,
    input  wire [4:0]      fp_wr_idx,
    input  wire [XLEN-1:0] fp_wr_data,
    // Fetch exception
    input  wire            fetch_fault_in,
    output reg             fetch_fault,
    // Reservation
    input  wire            load_locked,
    input  wire [XLEN-1:0] load_locked_addr,
    input  wire            store_conditional,
    input  wire            lock_clear,
    output reg             lock_flag,
    output reg  [XLEN-1:0] locked_physical_address
);
    reg        rst_meta_reg;
    reg        rst_sync_reg;
    reg [XLEN-3:0] pc_reg;
    reg [XLEN-3:0] pc_next;
    wire [XLEN-1:0] int_wr_mux;
    wire            int_wr_go;
    reg  [XLEN-1:0] fp_wr_mux;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // The updated PC is what every consumer sees, including the link value.
    assign pc_value = {pc_reg, 2'b00}; // RULE_06 RULE_07 RULE_08

    always @* begin
        pc_next = pc_reg;
        if (decode_valid) begin
            pc_next = pc_reg + `PRS_PC_INC; // RULE_06
        end
        if (pc_load) begin
            pc_next = pc_target[XLEN-1:2]; // RULE_07 RULE_12
        end
    end

    always @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pc_reg <= `PRS_PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // A link write has priority; to index 31 it is dropped in the bank while the jump still lands.
    assign int_wr_go  = int_wr_en | link_write; // RULE_12
    assign int_wr_mux = link_write ? pc_value : int_wr_data;

    prs_bank #(
        .WIDTH (XLEN),
        .DEPTH (32)
    ) u_int_bank ( // RULE_09
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_reg),
        .rd_a_idx   (int_rd_a_idx),
        .rd_b_idx   (int_rd_b_idx),
        .rd_a_data  (int_rd_a_data),
        .rd_b_data  (int_rd_b_data),
        .wr_en      (int_wr_go),
        .wr_idx     (link_write ? link_idx : int_wr_idx),
        .wr_data    (int_wr_mux)
    );

    // Longword operands with the ignored gap bits masked off.
    assign fp_rd_a_lw = {fp_rd_a_data[XLEN-1:`PRS_LW_GAP_HI+1], 3'b000,
                         fp_rd_a_data[`PRS_LW_GAP_LO-1:0]}; // RULE_01 RULE_02
    assign fp_rd_b_lw = {fp_rd_b_data[XLEN-1:`PRS_LW_GAP_HI+1], 3'b000,
                         fp_rd_b_data[`PRS_LW_GAP_LO-1:0]}; // RULE_01 RULE_02

    // Writes always carry all 64 bits; only the longword operate result gets its gap forced.
    always @* begin
        fp_wr_mux = fp_wr_data; // RULE_03 RULE_04 RULE_18
        case (fp_wr_op)
            `PRS_OP_LW_OPERATE: begin
                fp_wr_mux = {fp_wr_data[XLEN-1:`PRS_LW_GAP_HI+1], 3'b000,
                             fp_wr_data[`PRS_LW_GAP_LO-1:0]}; // RULE_01
            end
            default: begin
                fp_wr_mux = fp_wr_data;
            end
        endcase
    end

    // Stores read the register as-is with no checks.
    prs_bank #(
        .WIDTH (XLEN),
        .DEPTH (32)
    ) u_fp_bank ( // RULE_15 RULE_05
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_reg),
        .rd_a_idx   (fp_rd_a_idx),
        .rd_b_idx   (fp_rd_b_idx),
        .rd_a_data  (fp_rd_a_data),
        .rd_b_data  (fp_rd_b_data),
        .wr_en      (fp_wr_en),
        .wr_idx     (fp_wr_idx),
        .wr_data    (fp_wr_mux)
    );

    // The optional prefetch instructions are not built here, so no prefetch state exists and none is reachable.
    // RULE_20

    // Fetch faults pass regardless of destination index.
    always @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            fetch_fault <= 1'b0;
        end else begin
            fetch_fault <= fetch_fault_in; // RULE_13
        end
    end

    // A load-locked to index 31 is left to update like any other: the state is then unspecified.
    always @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            lock_flag               <= 1'b0;
            locked_physical_address <= {XLEN{1'b0}};
        end else if (load_locked) begin
            lock_flag               <= 1'b1; // RULE_19 RULE_14
            locked_physical_address <= load_locked_addr;
        end else if (store_conditional || lock_clear) begin
            lock_flag               <= 1'b0; // RULE_19
        end
    end
endmodule // prs_register_state

// ---- test/prs_pipe_model.sv ----
// Decode stream model standing in for the pipeline.
`timescale 1ns/1ps
module prs_pipe_model (
    // Clock and decode stream
    input  wire sys_clk,
    output reg  decode_valid,
    output reg  fetch_fault_in
);
    initial decode_valid = 1'b0;
    initial fetch_fault_in = 1'b0;
    // Decodes go back to back; slot f carries a fetch fault.
    task issue(input [3:0] n, input [3:0] f);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            @(posedge sys_clk);
            #2 decode_valid = 1'b1;
            fetch_fault_in = (i == f);
        end
        @(posedge sys_clk);
        #2 decode_valid = 1'b0;
        fetch_fault_in = 1'b0;
    endtask
endmodule // prs_pipe_model

// ---- test/prs_register_state_monitor.sv ----
// Port checker for the processor register state block.
`timescale 1ns/1ps
module prs_monitor (
    input wire        sys_clk, rst_b, decode_valid, pc_load, link_write, int_wr_en, fp_wr_en,
    input wire        fetch_fault_in, fetch_fault, load_locked, lock_flag,
    input wire [4:0]  int_rd_a_idx, int_wr_idx, fp_rd_a_idx, fp_rd_b_idx, fp_wr_idx,
    input wire [2:0]  fp_wr_op,
    input wire [63:0] pc_target, pc_value, int_rd_a_data, int_wr_data, fp_rd_a_data, fp_rd_b_data,
    input wire [63:0] fp_rd_a_lw, fp_wr_data, load_locked_addr, locked_physical_address
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_int_wr;
        int_wr_en && !link_write && int_wr_idx != 5'h1f && int_rd_a_idx == int_wr_idx ##1 !int_wr_en && $stable(int_rd_a_idx);
    endsequence
    sequence s_fp_wr;
        fp_wr_en && fp_wr_idx != 5'h1f && fp_rd_a_idx == fp_wr_idx ##1 !fp_wr_en && $stable(fp_rd_a_idx);
    endsequence
    property p_pc_low; pc_value[1:0] == 2'h0; endproperty
    property p_pc_adv; decode_valid && !pc_load |=> pc_value == $past(pc_value) + 64'h4; endproperty
    property p_pc_load; pc_load |=> pc_value == ($past(pc_target) & 64'hffff_ffff_ffff_fffc); endproperty
    property p_int_zero; int_rd_a_idx == 5'h1f |-> int_rd_a_data == 64'h0; endproperty
    property p_fp_zero; fp_rd_b_idx == 5'h1f |-> fp_rd_b_data == 64'h0; endproperty
    property p_lw_view; fp_rd_a_lw == (fp_rd_a_data & 64'hc7ff_ffff_ffff_ffff); endproperty
    property p_int_wr; s_int_wr |-> int_rd_a_data == $past(int_wr_data); endproperty
    property p_fp_wr;
        s_fp_wr |-> fp_rd_a_data == ($past(fp_wr_op) == 3'h1 ? $past(fp_wr_data) & 64'hc7ff_ffff_ffff_ffff
                                                             : $past(fp_wr_data));
    endproperty
    property p_fault; 1'b1 |=> fetch_fault == $past(fetch_fault_in); endproperty
    property p_lock; load_locked |=> lock_flag && locked_physical_address == $past(load_locked_addr); endproperty
    a_pc_low: assert property (p_pc_low) else $error("pc low bits set");
    a_pc_adv: assert property (p_pc_adv) else $error("pc did not advance by four");
    a_pc_load: assert property (p_pc_load) else $error("pc target not taken");
    a_int_zero: assert property (p_int_zero) else $error("integer zero register not zero");
    a_fp_zero: assert property (p_fp_zero) else $error("floating zero register not zero");
    a_lw_view: assert property (p_lw_view) else $error("longword view wrong");
    a_int_wr: assert property (p_int_wr) else $error("integer write lost");
    a_fp_wr: assert property (p_fp_wr) else $error("floating write wrong");
    a_fault: assert property (p_fault) else $error("fetch fault not passed on");
    a_lock: assert property (p_lock) else $error("reservation not taken");
endmodule // prs_monitor

// ---- test/prs_register_state_tb.sv ----
// Self-checking bench for the processor register state block.
`timescale 1ns/1ps
module prs_register_state_tb;
    reg         sys_clk = 1'b0, rst_b = 1'b0, pc_load = 1'b0, link_write = 1'b0, int_wr_en = 1'b0, fp_wr_en = 1'b0;
    reg         load_locked = 1'b0, lock_clear = 1'b0, store_conditional = 1'b0;
    reg  [4:0]  link_idx = 5'h0, int_rd_a_idx = 5'h0, int_rd_b_idx = 5'h0, int_wr_idx = 5'h0;
    reg  [4:0]  fp_rd_a_idx = 5'h0, fp_rd_b_idx = 5'h0, fp_wr_idx = 5'h0;
    reg  [2:0]  fp_wr_op = 3'h0;
    reg  [63:0] pc_target = 64'h0, int_wr_data = 64'h0, fp_wr_data = 64'h0, load_locked_addr = 64'h0, pc0;
    wire        decode_valid, fetch_fault_in, fetch_fault, lock_flag;
    wire [63:0] pc_value, int_rd_a_data, int_rd_b_data, fp_rd_a_data, fp_rd_b_data, fp_rd_a_lw, fp_rd_b_lw;
    wire [63:0] locked_physical_address;
    integer     errors = 0, comparisons = 0, k;
    always #12.5 sys_clk = ~sys_clk;
    prs_pipe_model m (.sys_clk(sys_clk), .decode_valid(decode_valid), .fetch_fault_in(fetch_fault_in));
    prs_register_state uut (.*);
    task chk(input [63:0] got, input [63:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge sys_clk);
        #2;
    endtask
    task finish_test;
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task t_pc;
        pc0 = pc_value;
        m.issue(4'h5, 4'h2);
        chk(pc_value, pc0 + 64'h14);
        pc_target = 64'h0000_1234_5678_9abf;
        pc_load = 1'b1;
        link_write = 1'b1;
        link_idx = 5'h1f;
        int_rd_a_idx = 5'h1f;
        tick;
        pc_load = 1'b0;
        chk(pc_value, 64'h0000_1234_5678_9abc);
        chk(int_rd_a_data, 64'h0);
        link_idx = 5'h5;
        tick;
        link_write = 1'b0;
        int_rd_a_idx = 5'h5;
        tick;
        chk(int_rd_a_data, 64'h0000_1234_5678_9abc);
    endtask
    task t_int;
        int_wr_en = 1'b1;
        int_wr_idx = 5'h1f;
        int_wr_data = 64'hffff_ffff_ffff_ffff;
        tick;
        int_wr_idx = 5'h3;
        int_wr_data = 64'hdead_beef_0123_4567;
        int_rd_a_idx = 5'h3;
        int_rd_b_idx = 5'h1f;
        tick;
        int_wr_en = 1'b0;
        tick;
        chk(int_rd_a_data, 64'hdead_beef_0123_4567);
        chk(int_rd_b_data, 64'h0);
    endtask
    task t_fp;
        fp_wr_data = 64'hffff_0000_ffff_0000;
        fp_wr_idx = 5'h7;
        fp_rd_a_idx = 5'h7;
        fp_rd_b_idx = 5'h1f;
        for (k = 0; k < 5; k = k + 1) begin
            fp_wr_en = 1'b1;
            fp_wr_op = k[2:0];
            fp_wr_data = ~fp_wr_data;
            tick;
            fp_wr_en = 1'b0;
            tick;
            chk(fp_rd_a_data, (k == 1) ? fp_wr_data & 64'hc7ff_ffff_ffff_ffff : fp_wr_data);
            chk(fp_rd_a_lw, fp_wr_data & 64'hc7ff_ffff_ffff_ffff);
        end
        fp_wr_en = 1'b1;
        fp_wr_idx = 5'h1f;
        tick;
        fp_wr_en = 1'b0;
        tick;
        chk(fp_rd_b_data, 64'h0);
    endtask
    task t_lock;
        load_locked = 1'b1;
        load_locked_addr = 64'h0000_0000_8000_1238;
        tick;
        load_locked = 1'b0;
        chk({63'h0, lock_flag}, 64'h1);
        chk(locked_physical_address, 64'h0000_0000_8000_1238);
        lock_clear = 1'b1;
        tick;
        lock_clear = 1'b0;
        chk({63'h0, lock_flag}, 64'h0);
        load_locked = 1'b1;
        tick;
        load_locked = 1'b0;
        store_conditional = 1'b1;
        tick;
        store_conditional = 1'b0;
        chk({63'h0, lock_flag}, 64'h0);
        m.issue(4'h1, 4'h0);
        chk({63'h0, fetch_fault}, 64'h1);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #2 rst_b = 1'b1;
        repeat (3) tick;
        t_pc;
        t_int;
        t_fp;
        t_lock;
        finish_test;
    end
    initial begin
        #10000;
        errors = errors + 1;
        finish_test;
    end
endmodule // prs_register_state_tb
bind prs_register_state prs_monitor mon (.*);
